// ### inc/fcec_pkg.sv
// Package with offsets, field positions, reset values and states of the flash config block.
package fcec_pkg;
  // Register indexes; the Wishbone byte address is four times the index.
  localparam logic [3:0] FCEC_CFG_IDX = 4'h4;
  localparam logic [3:0] FCEC_ERR_IDX = 4'h5;
  localparam logic [3:0] FCEC_STAT_IDX = 4'h6;
  // Field positions in flash_config.
  localparam int FCEC_CMD_DONE_IRQ_EN_BIT = 7;
  localparam int FCEC_ERSA_BIT = 5;
  localparam int FCEC_IGN_BIT = 4;
  localparam int FCEC_WAIT_LO = 2;
  localparam int FCEC_FDF_BIT = 1;
  localparam int FCEC_FSF_BIT = 0;
  // Field positions in flash_error_config and the status register.
  localparam int FCEC_SFIE_BIT = 0;
  localparam int FCEC_ACK_BIT = 0;
  localparam int FCEC_BUSY_BIT = 1;
  // Values after reset and wait codes.
  localparam logic [1:0] FCEC_WAIT_MAX = 2'h0;
  localparam logic [1:0] FCEC_WAIT_OFF = 2'h3;
  localparam logic [1:0] FCEC_WAIT_RST = FCEC_WAIT_MAX;
  localparam logic [7:0] FCEC_ZERO_BYTE = 8'h00;
  localparam int FCEC_MAX_WAIT_CYC = 1;
  // Operation codes handed to the memory controller.
  localparam logic [1:0] FCEC_OP_ERASE = 2'h0;
  localparam logic [1:0] FCEC_OP_VERIFY = 2'h1;
  localparam logic [1:0] FCEC_OP_PROG = 2'h2;
  // Erase-all sequencer states.
  typedef enum logic [4:0] {
    FCEC_IDLE = 5'h01,
    FCEC_ERASE = 5'h02,
    FCEC_VERIFY = 5'h04,
    FCEC_PROG = 5'h08,
    FCEC_UNSEC = 5'h10
  } fcec_state_t;
endpackage

// ### core/fcec_top.sv
// Flash configuration and error configuration registers with read timing and erase-all logic.
`timescale 1ns/1ps
module fcec_top #(
  parameter int MAX_WAIT = fcec_pkg::FCEC_MAX_WAIT_CYC // Wait cycles at maximum setting.
) (
  input wire logic clk_i, // 125 MHz bus clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [7:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  input wire logic cmd_done_flag_i, // Command-done flag from status register.
  input wire logic single_fault_flag_i, // Single-fault flag from error status.
  input wire logic erase_all_pin_i, // Chip-level erase-all request pin.
  input wire logic rd_req_i, // Array read request pulse.
  input wire logic ecc_single_i, // Real single-bit fault of current read.
  input wire logic ecc_double_i, // Real double-bit fault of current read.
  input wire logic seq_done_i, // Memory controller finished an operation.
  output logic rd_done_o, // Array read data valid pulse.
  output logic set_single_fault_o, // Set pulse for the single-fault flag.
  output logic set_double_fault_o, // Set pulse for the double-fault flag.
  output logic cmd_done_irq_o, // Command-done interrupt request.
  output logic single_fault_irq_o, // Single-fault interrupt request.
  output logic wait_switch_ack_o, // Wait-state switch acknowledge.
  output logic [1:0] seq_op_o, // Operation code for memory controller.
  output logic seq_go_o, // Start pulse for memory controller.
  output logic security_unsec_o, // Pulse: set security state unsecured.
  output logic seq_busy_o // Erase-all sequence in progress.
);
  import fcec_pkg::*;

  // Register state.
  logic cmd_done_irq_en;
  logic ignore_single_fault;
  logic [1:0] read_wait_cfg;
  logic force_double_fault;
  logic force_single_fault;
  logic single_fault_irq_en;
  logic erase_all_request;
  logic wait_switch_ack;
  logic [1:0] eff_wait;
  logic wait_pend;
  fcec_state_t state;
  fcec_state_t next_state;

  // Two flip-flops guard the asynchronous erase-all pin.
  logic ersa_meta;
  logic ersa_sync;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ersa_meta <= 1'b0;
      ersa_sync <= 1'b0;
    end else begin
      ersa_meta <= erase_all_pin_i;
      ersa_sync <= ersa_meta;
    end
  end

  // Bus decode; a write lands on the edge at which ack is sampled.
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire [3:0] reg_idx = wb_adr_i[5:2];
  wire adr_hi_ok = (wb_adr_i[7:6] == 2'h0) & (wb_adr_i[1:0] == 2'h0);
  wire hit_cfg = adr_hi_ok & (reg_idx == FCEC_CFG_IDX);
  wire hit_err = adr_hi_ok & (reg_idx == FCEC_ERR_IDX);
  wire hit_stat = adr_hi_ok & (reg_idx == FCEC_STAT_IDX);
  wire wr_en = bus_req & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire wr_cfg = wr_en & hit_cfg;
  wire wr_err = wr_en & hit_err;
  // Wait field writes during a running command are dropped; the other fields still land.
  wire wr_wait = wr_cfg & cmd_done_flag_i;
  // Write fields are picked out once, so the registers and their checks share one source.
  wire [1:0] wait_wr_field = wb_dat_i[FCEC_WAIT_LO +: 2];
  wire sfie_wr_bit = wb_dat_i[FCEC_SFIE_BIT];

  // Read mux; unused bits and unmapped addresses read zero.
  wire [7:0] cfg_rd = {cmd_done_irq_en, 1'b0, erase_all_request,
                       ignore_single_fault, read_wait_cfg,
                       force_double_fault, force_single_fault};
  wire [7:0] err_rd = {7'h00, single_fault_irq_en};
  wire [7:0] stat_rd = {6'h00, seq_busy_o, wait_switch_ack};
  wire [7:0] rd_byte = hit_cfg ? cfg_rd :
                       hit_err ? err_rd :
                       hit_stat ? stat_rd : FCEC_ZERO_BYTE;

  // Ack is given one cycle after the request and dropped the next cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // Configuration fields; forcing bits change only by software writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_done_irq_en <= 1'b0;
      ignore_single_fault <= 1'b0;
      read_wait_cfg <= FCEC_WAIT_RST;
      force_double_fault <= 1'b0;
      force_single_fault <= 1'b0;
      single_fault_irq_en <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cmd_done_irq_en <= wb_dat_i[FCEC_CMD_DONE_IRQ_EN_BIT];
        ignore_single_fault <= wb_dat_i[FCEC_IGN_BIT];
        force_double_fault <= wb_dat_i[FCEC_FDF_BIT];
        force_single_fault <= wb_dat_i[FCEC_FSF_BIT];
      end
      if (wr_wait) begin
        read_wait_cfg <= wait_wr_field;
      end
      if (wr_err) begin
        single_fault_irq_en <= sfie_wr_bit;
      end
    end
  end

  // Array read timing: one base cycle plus the effective wait count.
  logic rd_busy;
  logic [7:0] rd_cnt;
  wire wait_off = (eff_wait == FCEC_WAIT_OFF);
  // Reserved codes fall through to the maximum count.
  wire [7:0] wait_cyc = wait_off ? 8'h00 : 8'(MAX_WAIT);
  wire rd_start = rd_req_i & ~rd_busy;
  wire rd_last = rd_busy & (rd_cnt == 8'h00);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_busy <= 1'b0;
      rd_cnt <= 8'h00;
    end else if (rd_start) begin
      rd_busy <= 1'b1;
      rd_cnt <= wait_cyc;
    end else if (rd_last) begin
      rd_busy <= 1'b0;
    end else if (rd_busy) begin
      rd_cnt <= rd_cnt - 8'h01;
    end
  end

  // Fault reporting on read completion, forced or real.
  wire sf_hit = (ecc_single_i | force_single_fault) & ~ignore_single_fault;
  wire df_hit = ecc_double_i | force_double_fault;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_done_o <= 1'b0;
      set_single_fault_o <= 1'b0;
      set_double_fault_o <= 1'b0;
    end else begin
      rd_done_o <= rd_last;
      set_single_fault_o <= rd_last & sf_hit;
      set_double_fault_o <= rd_last & df_hit;
    end
  end

  // The new wait code takes effect only between reads, so a read in flight
  // never sees its timing change under it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eff_wait <= FCEC_WAIT_RST;
      wait_pend <= 1'b0;
      wait_switch_ack <= 1'b1;
    end else if (wr_wait) begin
      wait_pend <= 1'b1;
      wait_switch_ack <= 1'b0;
    end else if (wait_pend & ~rd_busy & ~rd_req_i) begin
      eff_wait <= read_wait_cfg;
      wait_pend <= 1'b0;
      wait_switch_ack <= 1'b1;
    end
  end
  assign wait_switch_ack_o = wait_switch_ack;

  // Interrupt requests are plain flag-and-enable terms.
  assign cmd_done_irq_o = cmd_done_flag_i & cmd_done_irq_en;
  assign single_fault_irq_o = single_fault_flag_i & single_fault_irq_en;

  // Erase-all sequencer; it only starts while no command runs.
  wire ersa_start = (state == FCEC_IDLE) & ersa_sync & cmd_done_flag_i;
  always_comb begin
    next_state = state;
    unique case (state)
      FCEC_IDLE: begin
        if (ersa_start) begin
          next_state = FCEC_ERASE;
        end
      end
      FCEC_ERASE: begin
        if (seq_done_i) begin
          next_state = FCEC_VERIFY;
        end
      end
      FCEC_VERIFY: begin
        if (seq_done_i) begin
          next_state = FCEC_PROG;
        end
      end
      FCEC_PROG: begin
        if (seq_done_i) begin
          next_state = FCEC_UNSEC;
        end
      end
      FCEC_UNSEC: begin
        next_state = FCEC_IDLE;
      end
      default: begin
        next_state = FCEC_IDLE;
      end
    endcase
  end

  // Sequencer registers and the handshake to the memory controller.
  wire step = seq_done_i & (state != FCEC_IDLE) & (state != FCEC_UNSEC);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= FCEC_IDLE;
      erase_all_request <= 1'b0;
      seq_go_o <= 1'b0;
      seq_op_o <= FCEC_OP_ERASE;
      security_unsec_o <= 1'b0;
    end else begin
      state <= next_state;
      seq_go_o <= ersa_start | (step & (state != FCEC_PROG));
      security_unsec_o <= (state == FCEC_UNSEC);
      if (ersa_start) begin
        erase_all_request <= 1'b1;
        seq_op_o <= FCEC_OP_ERASE;
      end else if (state == FCEC_UNSEC) begin
        erase_all_request <= 1'b0;
      end
      if (step & (state == FCEC_ERASE)) begin
        seq_op_o <= FCEC_OP_VERIFY;
      end else if (step & (state == FCEC_VERIFY)) begin
        seq_op_o <= FCEC_OP_PROG;
      end
    end
  end
  assign seq_busy_o = erase_all_request;

  // Checks of the behaviour above.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_cmd_irq_gate: assert property (
    cmd_done_irq_o == (cmd_done_flag_i & cmd_done_irq_en))
    else $error("Command-done interrupt does not follow flag and enable.");

  a_sf_irq_gate: assert property (
    single_fault_irq_o == (single_fault_flag_i & single_fault_irq_en))
    else $error("Single-fault interrupt does not follow flag and enable.");

  a_wait_write_drop: assert property (
    (wr_cfg & ~cmd_done_flag_i) |=> $stable(read_wait_cfg))
    else $error("Wait field changed while a command was running.");

  a_ack_clears: assert property (
    wr_wait |=> ~wait_switch_ack_o)
    else $error("Switch ack not cleared by a wait field write.");

  a_ack_returns: assert property (
    (wait_pend & ~rd_busy & ~rd_req_i & ~wr_wait) |=>
      (wait_switch_ack_o & (eff_wait == $past(read_wait_cfg))))
    else $error("Switch ack not restored once reads use the new setting.");

  a_read_max_wait: assert property (
    (rd_start & (eff_wait != FCEC_WAIT_OFF)) |=> ~rd_last ##1 rd_last ##1 rd_done_o)
    else $error("Read at maximum setting did not take one wait cycle.");

  a_read_no_wait: assert property (
    (rd_start & (eff_wait == FCEC_WAIT_OFF)) |=> rd_last ##1 rd_done_o)
    else $error("Read with wait-states off did not finish at once.");

  a_force_double: assert property (
    (rd_last & force_double_fault) |=> set_double_fault_o)
    else $error("Forced double fault not reported on a read.");

  a_ignore_single: assert property (
    ignore_single_fault |=> ~set_single_fault_o)
    else $error("Single fault reported while ignored.");

  a_force_single: assert property (
    (rd_last & force_single_fault & ~ignore_single_fault) |=> set_single_fault_o)
    else $error("Forced single fault not reported on a read.");

  a_force_hold: assert property (
    (force_single_fault & ~wr_cfg) |=> force_single_fault)
    else $error("Force-single bit cleared without a software write.");

  a_ersa_set: assert property (
    ersa_start |=> (erase_all_request & seq_go_o & (seq_op_o == FCEC_OP_ERASE)))
    else $error("Erase-all request did not start the sequence.");

  a_ersa_clear: assert property (
    (state == FCEC_UNSEC) |=> (~erase_all_request & security_unsec_o))
    else $error("Erase-all request not cleared with unsecure step.");

  a_ersa_order: assert property (
    (state == FCEC_PROG) |-> (seq_op_o == FCEC_OP_PROG))
    else $error("Program step issued with wrong operation code.");

  a_ersa_readonly: assert property (
    (wr_cfg & ~ersa_start & (state == FCEC_IDLE)) |=> ~erase_all_request)
    else $error("Erase-all request changed by a software write.");

  a_wait_reset: assert property (
    $fell(rst_i) |-> ((read_wait_cfg == FCEC_WAIT_RST) & wait_switch_ack_o & ~seq_busy_o))
    else $error("Wait field, switch ack or busy wrong after reset.");

  a_double_real: assert property (
    (rd_last & ~force_double_fault & ~ecc_double_i) |=> ~set_double_fault_o)
    else $error("Double fault reported without a real or forced fault.");

  a_single_real: assert property (
    (rd_last & ~force_single_fault & ~ecc_single_i) |=> ~set_single_fault_o)
    else $error("Single fault reported without a real or forced fault.");

  a_single_report: assert property (
    (rd_last & ecc_single_i & ~ignore_single_fault) |=> set_single_fault_o)
    else $error("Real single fault not reported while not ignored.");

  a_err_write: assert property (
    wr_err |=> (single_fault_irq_en == $past(sfie_wr_bit)))
    else $error("Error configuration write did not land.");

  a_wait_take: assert property (
    wr_wait |=> (read_wait_cfg == $past(wait_wr_field)))
    else $error("Wait field write with no command running did not land.");

  a_wait_hold_busy: assert property (
    rd_busy |=> $stable(eff_wait))
    else $error("Effective wait setting changed under a read in flight.");

  a_ersa_refused: assert property (
    (~cmd_done_flag_i & (state == FCEC_IDLE)) |=> ~erase_all_request)
    else $error("Erase-all request set while a command was running.");

  a_rd_reserved: assert property (
    (rd_start & (eff_wait != FCEC_WAIT_MAX) & (eff_wait != FCEC_WAIT_OFF)) |=> ~rd_last)
    else $error("Reserved wait code did not insert the maximum wait.");

  a_fdf_hold: assert property (
    (force_double_fault & ~wr_cfg) |=> force_double_fault)
    else $error("Force-double bit cleared without a software write.");

  a_irq_en_hold: assert property (
    (cmd_done_irq_en & ~wr_cfg) |=> cmd_done_irq_en)
    else $error("Command-done interrupt enable dropped without a write.");
endmodule

// ### verification/fcec_tb.sv
// Self-checking testbench for the flash configuration register block.
`timescale 1ns/1ps
module tb;
  import fcec_pkg::*;
  localparam int MAX_WAIT = 1;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, rd_done_o, set_single_fault_o, set_double_fault_o, cmd_done_irq_o;
  logic single_fault_irq_o, wait_switch_ack_o, seq_go_o, security_unsec_o, seq_busy_o;
  logic [1:0] seq_op_o;
  logic cmd_done_flag_i = 1'b0, single_fault_flag_i = 1'b0, erase_all_pin_i = 1'b0;
  logic rd_req_i = 1'b0, ecc_single_i = 1'b0, ecc_double_i = 1'b0, seq_done_i = 1'b0;
  logic [31:0] rnd = 32'h0000_59f9;
  logic [7:0] cfg = 8'h00;
  logic [1:0] f;
  logic [31:0] q_bus[$];
  logic [1:0] q_flt[$];
  int q_lat[$];
  int fails = 0, tests_run = 0, cnt = 0, rd_start = 0, i;

  fcec_top #(.MAX_WAIT(MAX_WAIT)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cmd_done_flag_i(cmd_done_flag_i), .single_fault_flag_i(single_fault_flag_i),
    .erase_all_pin_i(erase_all_pin_i), .rd_req_i(rd_req_i), .ecc_single_i(ecc_single_i),
    .ecc_double_i(ecc_double_i), .seq_done_i(seq_done_i), .rd_done_o(rd_done_o),
    .set_single_fault_o(set_single_fault_o), .set_double_fault_o(set_double_fault_o),
    .cmd_done_irq_o(cmd_done_irq_o), .single_fault_irq_o(single_fault_irq_o),
    .wait_switch_ack_o(wait_switch_ack_o), .seq_op_o(seq_op_o), .seq_go_o(seq_go_o),
    .security_unsec_o(security_unsec_o), .seq_busy_o(seq_busy_o));

  // Free-running 125 MHz clock.
  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // Xorshift generator that feeds the fault inputs.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic bad(input string m);
    fails++;
    $display("wrong value at %0t: %s", $time, m);
  endtask

  task automatic cmp_bus(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) bad(m);
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string m);
    tests_run++;
    if (got !== exp) bad(m);
  endtask

  task automatic cmp_lat(input int got, input int exp);
    tests_run++;
    if (got != exp) bad("read latency");
  endtask

  // One classic Wishbone cycle; the request is held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h00_0000, d};
    @(posedge clk_i iff wb_ack_o === 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // The shadow copy keeps the old wait field when the done flag is low.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h10) cfg = cmd_done_flag_i ? (d & 8'h9f) : ((d & 8'h93) | (cfg & 8'h0c));
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    q_bus.push_back({24'h00_0000, exp});
    wb(1'b0, a, 8'h00);
  endtask

  // Array read with random real faults; expectations come from the shadow copy.
  task automatic arr_rd();
    logic s, d;
    rnd = xs(rnd);
    s = rnd[0];
    d = rnd[1];
    q_lat.push_back(cfg[3:2] == FCEC_WAIT_OFF ? 3 : 3 + MAX_WAIT);
    q_flt.push_back({(s | cfg[FCEC_FSF_BIT]) & ~cfg[FCEC_IGN_BIT], d | cfg[FCEC_FDF_BIT]});
    @(posedge clk_i);
    rd_req_i <= 1'b1;
    ecc_single_i <= s;
    ecc_double_i <= d;
    rd_start = cnt;
    @(posedge clk_i);
    rd_req_i <= 1'b0;
    @(posedge clk_i iff rd_done_o === 1'b1);
  endtask

  // Monitor: each result that appears takes the oldest note off its queue.
  always @(posedge clk_i) begin
    cnt <= cnt + 1;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && q_bus.size() > 0) begin
      cmp_bus(wb_dat_o, q_bus.pop_front(), "register read");
    end
    if (rd_done_o === 1'b1 && q_lat.size() > 0) begin
      f = q_flt.pop_front();
      cmp_lat(cnt - rd_start, q_lat.pop_front());
      cmp_bit(set_single_fault_o, f[1], "single fault set");
      cmp_bit(set_double_fault_o, f[0], "double fault set");
    end
  end

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog sized well above the expected several hundred cycles of the run.
  initial begin
    repeat (20000) @(posedge clk_i);
    bad("watchdog expired");
    stop_test();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h10, 8'h00);
    rd(8'h14, 8'h00);
    rd(8'h18, 8'h01);
    $display("test reset values finished");
    cmd_done_flag_i <= 1'b1;
    @(posedge clk_i);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h9f);
    wr(8'h14, 8'hff);
    rd(8'h14, 8'h01);
    wr(8'h20, 8'h00);
    rd(8'h20, 8'h00);
    rd(8'h10, cfg);
    $display("test access kinds finished");
    // Every combination of enable, flag and fault flag.
    for (i = 0; i < 8; i++) begin
      wr(8'h10, {i[2], 7'h1f});
      wr(8'h14, {7'h00, i[2]});
      @(posedge clk_i);
      cmd_done_flag_i <= i[0];
      single_fault_flag_i <= i[1];
      @(posedge clk_i);
      cmp_bit(cmd_done_irq_o, i[0] & i[2], "command irq");
      cmp_bit(single_fault_irq_o, i[1] & i[2], "fault irq");
    end
    $display("test interrupts finished");
    // All wait codes with every forcing and ignore setting, two reads each.
    for (i = 0; i < 32; i++) begin
      wr(8'h10, {3'b000, i[4:0]});
      arr_rd();
      arr_rd();
      rd(8'h10, cfg);
    end
    $display("test read timing and faults finished");
    // A held read request keeps the switch pending.
    @(posedge clk_i);
    rd_req_i <= 1'b1;
    wr(8'h10, 8'h0c);
    repeat (2) @(posedge clk_i);
    cmp_bit(wait_switch_ack_o, 1'b0, "switch ack pending");
    rd_req_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd(8'h18, 8'h01);
    cmd_done_flag_i <= 1'b0;
    @(posedge clk_i);
    wr(8'h10, 8'h80);
    rd(8'h10, cfg);
    rd(8'h18, 8'h01);
    $display("test wait switch finished");
    // Erase-all is refused while the flag is low, then runs its three steps.
    erase_all_pin_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    cmp_bit(seq_busy_o, 1'b0, "erase refused");
    cmd_done_flag_i <= 1'b1;
    for (i = 0; i < 3; i++) begin
      @(posedge clk_i iff seq_go_o === 1'b1);
      erase_all_pin_i <= 1'b0;
      cmp_bus({30'h0, seq_op_o}, i, "sequence step");
      cmp_bit(seq_busy_o, 1'b1, "erase busy");
      if (i == 0) rd(8'h10, cfg | 8'h20);
      repeat (3) @(posedge clk_i);
      seq_done_i <= 1'b1;
      @(posedge clk_i);
      seq_done_i <= 1'b0;
    end
    @(posedge clk_i iff security_unsec_o === 1'b1);
    cmp_bit(seq_busy_o, 1'b0, "erase finished");
    rd(8'h10, cfg);
    rd(8'h18, 8'h01);
    $display("test erase all finished");
    stop_test();
  end
endmodule
